/* File: verilog/msl_pkg.sv */
package msl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FS_HZ = 195_000;
  localparam int unsigned SMP_CYC = CLK_HZ / FS_HZ;
  localparam logic [7:0] SMP_LAST = 8'(SMP_CYC - 1);
  localparam int unsigned REF_STALL_US = 10_000;
  localparam int unsigned REF_STALL_CYC = REF_STALL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DGL_CYC = 3;

  // ----------------------------------------------------------------
  // data formats
  // ----------------------------------------------------------------
  localparam int unsigned DUTY_W = 12;
  localparam logic [11:0] DUTY_FULL = 12'h0fff;
  localparam int unsigned FRAC_W = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_FPOLE = 8'h0c;
  localparam logic [7:0] OFS_FZERO = 8'h10;
  localparam logic [7:0] OFS_LPOLE = 8'h14;
  localparam logic [7:0] OFS_LZERO = 8'h18;
  localparam logic [7:0] OFS_DCMD = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_DUTY = 8'h24;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FBYP = 2;
  localparam int unsigned CTRL_LBYP = 3;
  localparam int unsigned CTRL_EN = 4;
  localparam int unsigned CTRL_BRK = 5;
  localparam logic [1:0] SEL_FREQ = 2'h0;
  localparam logic [1:0] SEL_REFDUTY = 2'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CTRL_RST = 6'h0c;
  localparam logic [15:0] STEP_RST = 16'h0001;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [15:0] FPOLE_RST = 16'h0100;
  localparam logic [15:0] FZERO_RST = 16'h0080;
  localparam logic [15:0] LPOLE_RST = 16'h0100;
  localparam logic [15:0] LZERO_RST = 16'h0200;
  localparam logic [11:0] DCMD_RST = 12'h000;

  typedef enum logic [2:0] {
    MODE_FREQ = 3'b001,
    MODE_REFDUTY = 3'b010,
    MODE_REGDUTY = 3'b100
  } msl_mode_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } msl_div_t;

endpackage : msl_pkg

/* File: verilog/msl_speed_loop.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Functional notes
// - three speed modes chosen by select field
// - frequency mode: feedback tracks reference closed loop
// - reference duty mode: open loop measured duty
// - register duty mode: command over 4095
// - reference deglitched before speed comparison
// - compare reference, input_a: speed-up/slow-down pulses
// - integrator adds/subtracts step per divided tick
// - integrator cleared on disable, brake, reset
// - integrator saturates, never wraps
// - enable clears state; no reference, no drive in frequency mode
// - reference stopped: slow down until zero
// - one-pole one-zero filter after integrator
// - filter bypass bit passes input through
// - filter and lead sample at 195 kHz
// - lead compensator after filter, bypassable
// - dc gains 2xzero/pole and 0.5xzero/pole
// - filter and lead cleared while disabled
// - supports hall frequency up to 6.7 kHz
// - reference duty mode times input into 12 bits
// - 12-bit duty command register drives command
// - braking turns low sides on, clears integrator
// - lead bypass doubles duty command gain
module msl_speed_loop #(
  parameter int unsigned INT_W = 16,
  parameter int unsigned COEF_W = 16,
  parameter int unsigned DGL_N = msl_pkg::DGL_CYC,
  parameter int unsigned REF_STALL_CYC = msl_pkg::REF_STALL_CYC
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // motor side pins
  input wire logic I_REFERENCE_CLOCK_IN,
  input wire logic I_INPUT_A_FEEDBACK,
  output logic O_FEEDBACK_FREQ_OUT,
  output logic O_LOW_SIDE_ON,
  output logic [11:0] O_DUTY_CMD
);
  localparam int unsigned YW = INT_W + 32;
  localparam int unsigned FW = msl_pkg::FRAC_W;
  localparam logic [23:0] STALL_LIM = 24'(REF_STALL_CYC);
  localparam logic [3:0] DGL_LAST = 4'(DGL_N - 1);
  localparam logic signed [YW-1:0] Y_MAX = {{(YW - INT_W - FW){1'b0}}, {INT_W{1'b1}}, {FW{1'b0}}};
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q;
  logic [INT_W-1:0] step_q, integ_q, integ_d;
  logic [15:0] div_q, div_cnt_q, hi_cnt_q, per_cnt_q, dv_per_q;
  logic [COEF_W-1:0] fk1_q, fk2_q, ck1_q, ck2_q;
  logic [11:0] cmd_q, meas_q, duty_q, dv_quo_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, up_q, dn_q;
  logic ref_s1_q, ref_s2_q, ref_dgl_q, ref_prev_q;
  logic fb_s1_q, fb_s2_q, fb_prev_q, fbo_q, lso_q, en_prev_q;
  logic [3:0] dgl_cnt_q, dv_bit_q;
  logic [23:0] stall_cnt_q;
  logic [7:0] smp_cnt_q;
  logic signed [YW-1:0] fil_y_q, led_y_q;
  logic [INT_W-1:0] fil_xp_q, led_xp_q;
  logic [16:0] dv_rem_q;
  msl_pkg::msl_div_t dv_st_q;
  msl_pkg::msl_mode_t mode;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ----------------------------------------------------------------
  // apb and control decode
  // ----------------------------------------------------------------
  wire acc_req = I_PSEL & I_PENABLE & ~pready_q;
  wire acc_done = I_PSEL & I_PENABLE & pready_q;
  wire wr_en = acc_done & I_PWRITE;
  wire hit_ctrl = I_PADDR == msl_pkg::OFS_CTRL;
  wire hit_step = I_PADDR == msl_pkg::OFS_STEP;
  wire hit_div = I_PADDR == msl_pkg::OFS_DIV;
  wire hit_fpole = I_PADDR == msl_pkg::OFS_FPOLE;
  wire hit_fzero = I_PADDR == msl_pkg::OFS_FZERO;
  wire hit_lpole = I_PADDR == msl_pkg::OFS_LPOLE;
  wire hit_lzero = I_PADDR == msl_pkg::OFS_LZERO;
  wire hit_dcmd = I_PADDR == msl_pkg::OFS_DCMD;
  wire hit_stat = I_PADDR == msl_pkg::OFS_STAT;
  wire hit_duty = I_PADDR == msl_pkg::OFS_DUTY;
  wire hit_any = hit_ctrl | hit_step | hit_div | hit_fpole | hit_fzero | hit_lpole
                 | hit_lzero | hit_dcmd | hit_stat | hit_duty;
  wire [1:0] sel = ctrl_q[msl_pkg::CTRL_MODE_LSB +: 2];
  wire fbyp = ctrl_q[msl_pkg::CTRL_FBYP];
  wire lbyp = ctrl_q[msl_pkg::CTRL_LBYP];
  wire enable = ctrl_q[msl_pkg::CTRL_EN];
  wire brake = ctrl_q[msl_pkg::CTRL_BRK];
  wire run = enable & ~brake;
  wire en_rise = enable & ~en_prev_q;
  assign mode = (sel == msl_pkg::SEL_FREQ) ? msl_pkg::MODE_FREQ :
                (sel == msl_pkg::SEL_REFDUTY) ? msl_pkg::MODE_REFDUTY : msl_pkg::MODE_REGDUTY;
  wire freq_mode = mode == msl_pkg::MODE_FREQ;
  wire clear_loop = ~run | en_rise | ~freq_mode;
  // ----------------------------------------------------------------
  // reference and input_a conditioning
  // ----------------------------------------------------------------
  wire ref_rise = ref_dgl_q & ~ref_prev_q;
  wire fb_rise = fb_s2_q & ~fb_prev_q;
  wire stall = stall_cnt_q >= STALL_LIM;
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      {ref_s1_q, ref_s2_q, ref_dgl_q, ref_prev_q} <= 4'h0;
      {fb_s1_q, fb_s2_q, fb_prev_q, fbo_q} <= 4'h0;
      dgl_cnt_q <= 4'h0;
    end
    else
    begin
      ref_s1_q <= I_REFERENCE_CLOCK_IN;
      ref_s2_q <= ref_s1_q;
      fb_s1_q <= I_INPUT_A_FEEDBACK;
      fb_s2_q <= fb_s1_q;
      fb_prev_q <= fb_s2_q;
      fbo_q <= fb_s2_q;
      ref_prev_q <= ref_dgl_q;
      if (ref_s2_q == ref_dgl_q)
        dgl_cnt_q <= 4'h0;
      else if (dgl_cnt_q == DGL_LAST)
      begin
        ref_dgl_q <= ref_s2_q;
        dgl_cnt_q <= 4'h0;
      end
      else
        dgl_cnt_q <= dgl_cnt_q + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // speed differentiator and integrator
  // ----------------------------------------------------------------
  wire up_n = (up_q & ~stall) | ref_rise;
  wire dn_n = dn_q | fb_rise | (stall & (integ_q != '0));
  wire up_d = run & freq_mode & up_n & ~dn_n;
  wire dn_d = run & freq_mode & dn_n & ~up_n;
  wire [23:0] stall_d = ref_rise ? 24'h00_0000 : (stall ? stall_cnt_q : stall_cnt_q + 24'h00_0001);
  wire int_tick = ({1'b0, div_cnt_q} + 17'h0_0001) >= {1'b0, div_q};
  wire [15:0] div_cnt_d = int_tick ? 16'h0000 : div_cnt_q + 16'h0001;
  wire [INT_W:0] integ_sum = {1'b0, integ_q} + {1'b0, step_q};
  wire integ_below = integ_q < step_q;
  wire [INT_W-1:0] integ_diff = integ_q - step_q;
  wire [INT_W-1:0] integ_up = integ_sum[INT_W] ? {INT_W{1'b1}} : integ_sum[INT_W-1:0];
  wire [INT_W-1:0] integ_dn = integ_below ? '0 : integ_diff;
  assign integ_d = clear_loop ? '0 :
                   (int_tick & up_q & ~dn_q) ? integ_up :
                   (int_tick & dn_q & ~up_q) ? integ_dn : integ_q;
  // ----------------------------------------------------------------
  // filter and lead stages
  // ----------------------------------------------------------------
  // y holds FW fraction bits; dc gain kz/kp, plus unit feed-forward for the zero
  function automatic logic signed [YW-1:0] stage_f(input logic signed [YW-1:0] y,
      input logic [INT_W-1:0] x, input logic [INT_W-1:0] xp,
      input logic [COEF_W:0] kz, input logic [COEF_W-1:0] kp);
    logic signed [YW-1:0] zx, py, dx, t;
    zx = $signed(YW'(kz) * YW'(x));
    py = (y >>> FW) * $signed(YW'(kp));
    dx = ($signed(YW'(x)) - $signed(YW'(xp))) <<< FW;
    t = y + zx - py + dx;
    if (t < 0)
      t = '0;
    else if (t > Y_MAX)
      t = Y_MAX;
    return t;
  endfunction : stage_f
  wire smp_tick = smp_cnt_q == msl_pkg::SMP_LAST;
  wire [INT_W-1:0] fil_out = fbyp ? integ_q : fil_y_q[FW +: INT_W];
  wire [INT_W-1:0] led_out = lbyp ? fil_out : led_y_q[FW +: INT_W];
  wire [COEF_W:0] fil_kz = {fk2_q, 1'b0};
  wire [COEF_W:0] led_kz = {2'b00, ck2_q[COEF_W-1:1]};
  wire signed [YW-1:0] fil_y_n = stage_f(fil_y_q, integ_q, fil_xp_q, fil_kz, fk1_q);
  wire signed [YW-1:0] led_y_n = stage_f(led_y_q, fil_out, led_xp_q, led_kz, ck1_q);
  // ----------------------------------------------------------------
  // duty measurement and command selection
  // ----------------------------------------------------------------
  wire [16:0] rem2 = {dv_rem_q[15:0], 1'b0};
  wire rem_ge = rem2 >= {1'b0, dv_per_q};
  wire [16:0] rem_n = rem_ge ? rem2 - {1'b0, dv_per_q} : rem2;
  wire [11:0] quo_n = {dv_quo_q[10:0], rem_ge};
  wire dv_start = ref_rise & (per_cnt_q != 16'h0000);
  wire dv_full = hi_cnt_q >= per_cnt_q;
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      hi_cnt_q <= 16'h0000;
      per_cnt_q <= 16'h0000;
      dv_per_q <= 16'h0000;
      dv_rem_q <= 17'h0_0000;
      dv_quo_q <= 12'h000;
      dv_bit_q <= 4'h0;
      meas_q <= 12'h000;
      dv_st_q <= msl_pkg::DIV_IDLE;
    end
    else
    begin
      if (ref_rise)
      begin
        hi_cnt_q <= 16'h0000;
        per_cnt_q <= 16'h0000;
      end
      else if (per_cnt_q != 16'hffff)
      begin
        per_cnt_q <= per_cnt_q + 16'h0001;
        hi_cnt_q <= hi_cnt_q + {15'h0000, ref_dgl_q};
      end
      case (dv_st_q)
        msl_pkg::DIV_IDLE:
        begin
          if (dv_start & dv_full)
            meas_q <= msl_pkg::DUTY_FULL;
          else if (dv_start)
          begin
            dv_rem_q <= {1'b0, hi_cnt_q};
            dv_per_q <= per_cnt_q;
            dv_quo_q <= 12'h000;
            dv_bit_q <= 4'h0;
            dv_st_q <= msl_pkg::DIV_RUN;
          end
        end
        msl_pkg::DIV_RUN:
        begin
          dv_rem_q <= rem_n;
          dv_quo_q <= quo_n;
          dv_bit_q <= dv_bit_q + 4'h1;
          if (dv_bit_q == 4'hb)
          begin
            meas_q <= quo_n;
            dv_st_q <= msl_pkg::DIV_IDLE;
          end
        end
        default: dv_st_q <= msl_pkg::DIV_IDLE;
      endcase
    end
  end
  wire [11:0] loop_duty = led_out[INT_W-1 -: msl_pkg::DUTY_W];
  wire [11:0] meas_duty = stall ? (ref_dgl_q ? msl_pkg::DUTY_FULL : 12'h000) : meas_q;
  wire [11:0] sel_duty = freq_mode ? loop_duty :
                         (mode == msl_pkg::MODE_REFDUTY) ? meas_duty : cmd_q;
  wire [12:0] dbl_duty = {sel_duty, 1'b0};
  wire [11:0] gain_duty = ~lbyp ? sel_duty :
                          dbl_duty[12] ? msl_pkg::DUTY_FULL : dbl_duty[11:0];
  wire [11:0] duty_d = run ? gain_duty : 12'h000;
  // ----------------------------------------------------------------
  // loop state registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      {up_q, dn_q, en_prev_q, lso_q} <= 4'h0;
      stall_cnt_q <= 24'h00_0000;
      div_cnt_q <= 16'h0000;
      smp_cnt_q <= 8'h00;
      integ_q <= '0;
      {fil_y_q, led_y_q} <= '0;
      {fil_xp_q, led_xp_q} <= '0;
      duty_q <= 12'h000;
    end
    else
    begin
      up_q <= up_d;
      dn_q <= dn_d;
      en_prev_q <= enable;
      lso_q <= brake;
      stall_cnt_q <= stall_d;
      div_cnt_q <= div_cnt_d;
      smp_cnt_q <= smp_tick ? 8'h00 : smp_cnt_q + 8'h01;
      integ_q <= integ_d;
      duty_q <= duty_d;
      if (~run | en_rise)
      begin
        {fil_y_q, led_y_q} <= '0;
        {fil_xp_q, led_xp_q} <= '0;
      end
      else if (smp_tick)
      begin
        fil_y_q <= fil_y_n;
        fil_xp_q <= integ_q;
        led_y_q <= led_y_n;
        led_xp_q <= fil_out;
      end
    end
  end
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  wire [31:0] rd_stat = {13'h0000, stall, dn_q, up_q, 16'(integ_q)};
  wire [31:0] rd_duty = {4'h0, meas_duty, 4'h0, duty_q};
  wire [31:0] rdata = hit_ctrl ? {26'h000_0000, ctrl_q} :
                      hit_step ? 32'(step_q) :
                      hit_div ? {16'h0000, div_q} :
                      hit_fpole ? 32'(fk1_q) :
                      hit_fzero ? 32'(fk2_q) :
                      hit_lpole ? 32'(ck1_q) :
                      hit_lzero ? 32'(ck2_q) :
                      hit_dcmd ? {20'h0_0000, cmd_q} :
                      hit_stat ? rd_stat :
                      hit_duty ? rd_duty : 32'h0000_0000;
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      ctrl_q <= msl_pkg::CTRL_RST;
      step_q <= INT_W'(msl_pkg::STEP_RST);
      div_q <= msl_pkg::DIV_RST;
      fk1_q <= COEF_W'(msl_pkg::FPOLE_RST);
      fk2_q <= COEF_W'(msl_pkg::FZERO_RST);
      ck1_q <= COEF_W'(msl_pkg::LPOLE_RST);
      ck2_q <= COEF_W'(msl_pkg::LZERO_RST);
      cmd_q <= msl_pkg::DCMD_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc_req;
      if (acc_req)
      begin
        pslverr_q <= ~hit_any;
        prdata_q <= I_PWRITE ? 32'h0000_0000 : rdata;
      end
      if (wr_en & hit_ctrl)
        ctrl_q <= I_PWDATA[5:0];
      if (wr_en & hit_step)
        step_q <= I_PWDATA[INT_W-1:0];
      if (wr_en & hit_div)
        div_q <= I_PWDATA[15:0];
      if (wr_en & hit_fpole)
        fk1_q <= I_PWDATA[COEF_W-1:0];
      if (wr_en & hit_fzero)
        fk2_q <= I_PWDATA[COEF_W-1:0];
      if (wr_en & hit_lpole)
        ck1_q <= I_PWDATA[COEF_W-1:0];
      if (wr_en & hit_lzero)
        ck2_q <= I_PWDATA[COEF_W-1:0];
      if (wr_en & hit_dcmd)
        cmd_q <= I_PWDATA[11:0];
    end
  end
  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_FEEDBACK_FREQ_OUT = fbo_q;
  assign O_LOW_SIDE_ON = lso_q;
  assign O_DUTY_CMD = duty_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_integ_clear: assert property (clear_loop |=> integ_q == '0)
    else $error("integrator not cleared");
  a_integ_step_up: assert property (!clear_loop && int_tick && up_q && !dn_q
      && !integ_sum[INT_W] |=> integ_q == INT_W'($past(integ_q) + $past(step_q)))
    else $error("integrator step wrong");
  a_integ_floor: assert property (!clear_loop && int_tick && dn_q && !up_q
      && integ_below |=> integ_q == '0)
    else $error("integrator wrapped below zero");
  a_stage_clear: assert property (!run |=> fil_y_q == '0 && led_y_q == '0)
    else $error("filter state not cleared");
  a_duty_off: assert property (!run |=> O_DUTY_CMD == 12'h000)
    else $error("duty driven while disabled");
  a_reg_duty: assert property (run && mode == msl_pkg::MODE_REGDUTY && !lbyp
      |=> O_DUTY_CMD == $past(cmd_q))
    else $error("register duty not applied");
  a_bypass_gain: assert property (run && freq_mode && fbyp && lbyp && !integ_q[INT_W-1]
      |=> O_DUTY_CMD == {$past(integ_q[INT_W-2 -: 11]), 1'b0})
    else $error("bypass path gain wrong");
  a_sample_rate: assert property (smp_tick |-> ##102 smp_tick)
    else $error("sample tick spacing wrong");
  a_brake_low: assert property (brake |=> O_LOW_SIDE_ON)
    else $error("low sides not on in brake");
  a_stall_down: assert property (run && freq_mode && stall && integ_q != '0
      && !ref_rise |=> dn_q)
    else $error("no slow-down on stopped reference");
  a_ref_up: assert property (run && freq_mode && ref_rise && !fb_rise && !dn_q
      && !(stall && integ_q != '0) |=> up_q)
    else $error("speed-up missed");
  a_deglitch_hold: assert property ($changed(ref_dgl_q) |-> $past(ref_s2_q, 1) == ref_dgl_q
      && $past(ref_s2_q, 2) == ref_dgl_q && $past(ref_s2_q, 3) == ref_dgl_q)
    else $error("reference glitch passed");
  a_apb_ready: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("apb answer late");
endmodule : msl_speed_loop

/* File: verification/msl_far_side.sv */
`timescale 1ns/100ps
module msl_far_side (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // waveform setup, period zero stops the reference
  input wire logic [15:0] i_period,
  input wire logic [15:0] i_high,
  input wire logic i_input_a_lvl,
  // pins toward the block
  output logic o_ref,
  output logic o_input_a
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic wrap;

  assign wrap = (i_period == 16'h0000) || (cnt_q >= i_period - 16'h0001);
  assign cnt_d = wrap ? 16'h0000 : cnt_q + 16'h0001;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  // a stopped source rests low
  assign o_ref = (i_period != 16'h0000) && (cnt_q < i_high);
  assign o_input_a = i_input_a_lvl;
endmodule : msl_far_side

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } msl_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ref_pin;
  logic input_a_pin;
  logic fb_out;
  logic low_on;
  logic [11:0] duty;
  logic [15:0] period = 16'h0000;
  logic [15:0] high = 16'h0000;
  logic input_a_lvl = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int num_checks = 0;

  msl_row_t rows [14] = '{
    '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_000c, 1'b0},
    '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0001, 1'b0},
    '{1'b0, 8'h0c, 32'h0000_0000, 32'h0000_0100, 1'b0},
    '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0080, 1'b0},
    '{1'b0, 8'h14, 32'h0000_0000, 32'h0000_0100, 1'b0},
    '{1'b0, 8'h18, 32'h0000_0000, 32'h0000_0200, 1'b0},
    '{1'b0, 8'h1c, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, 8'h04, 32'h0000_abcd, 32'h0000_0000, 1'b0},
    '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_abcd, 1'b0},
    '{1'b1, 8'h1c, 32'hffff_fabc, 32'h0000_0000, 1'b0},
    '{1'b0, 8'h1c, 32'h0000_0000, 32'h0000_0abc, 1'b0},
    '{1'b1, 8'h28, 32'h0000_5555, 32'h0000_0000, 1'b1},
    '{1'b0, 8'h28, 32'h0000_0000, 32'h0000_0000, 1'b1}
  };

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  msl_speed_loop #(.REF_STALL_CYC(500)) msl_speed_loop_i (
    .I_CORE_CLK(clk),
    .I_SYS_RST(rst),
    .I_PSEL(psel),
    .I_PENABLE(penable),
    .I_PWRITE(pwrite),
    .I_PADDR(paddr),
    .I_PWDATA(pwdata),
    .O_PRDATA(prdata),
    .O_PREADY(pready),
    .O_PSLVERR(pslverr),
    .I_REFERENCE_CLOCK_IN(ref_pin),
    .I_INPUT_A_FEEDBACK(input_a_pin),
    .O_FEEDBACK_FREQ_OUT(fb_out),
    .O_LOW_SIDE_ON(low_on),
    .O_DUTY_CMD(duty)
  );

  msl_far_side msl_far_side_i (
    .i_clk(clk),
    .i_rst(rst),
    .i_period(period),
    .i_high(high),
    .i_input_a_lvl(input_a_lvl),
    .o_ref(ref_pin),
    .o_input_a(input_a_pin)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1'b1);
  endtask : apb

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      if (!rows[i].wr)
        chk(rdat, rows[i].exp);
      chk(rerr, rows[i].err);
    end
    input_a_lvl <= 1'b1;
    cyc(8);
    chk(fb_out, 1'b1);
    input_a_lvl <= 1'b0;
    apb(1'b1, 8'h1c, 32'h0000_0123);
    apb(1'b1, 8'h00, 32'h0000_0012);
    cyc(8);
    chk(duty, 12'h123);
    apb(1'b1, 8'h00, 32'h0000_001a);
    cyc(8);
    chk(duty, 12'h246);
    apb(1'b1, 8'h1c, 32'h0000_0fff);
    cyc(8);
    chk(duty, 12'hfff);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rdat[11:0], 12'hfff);
    apb(1'b1, 8'h00, 32'h0000_003a);
    cyc(4);
    chk(low_on, 1'b1);
    // frequency lock, no reference yet
    apb(1'b1, 8'h04, 32'h0000_ffff);
    apb(1'b1, 8'h00, 32'h0000_001c);
    cyc(300);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rdat[15:0], 16'h0000);
    chk(duty, 12'h000);
    chk(low_on, 1'b0);
    period <= 16'h0028;
    high <= 16'h0014;
    cyc(3000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rdat[15:0], 16'hffff);
    chk(duty, 12'hfff);
    apb(1'b1, 8'h00, 32'h0000_003c);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rdat[15:0], 16'h0000);
    apb(1'b1, 8'h00, 32'h0000_001c);
    cyc(3000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rdat[15:0], 16'hffff);
    period <= 16'h0000;
    cyc(2000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rdat[15:0], 16'h0000);
    chk(rdat[18], 1'b1);
    // reference duty, quarter high
    apb(1'b1, 8'h00, 32'h0000_0011);
    period <= 16'h0190;
    high <= 16'h0064;
    cyc(3000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rdat[27:16] > 12'h3f4 && rdat[27:16] < 12'h40a, 1'b1);
    chk(duty > 12'h3f4 && duty < 12'h40a, 1'b1);
    // reset in mid-run
    rst <= 1'b1;
    cyc(2);
    chk(duty, 12'h000);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rdat, 32'h0000_000c);
    wrap_up();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : tb_top
